/* File: logic/ima_alu.v */
// Combinational arithmetic and logic unit for the memory operand group.
`timescale 1ns/1ps
`include "ima_consts.vh"

module ima_alu (
	input  wire [7:0] accIn,    // Accumulator value.
	input  wire [7:0] memIn,    // Memory operand byte.
	input  wire       carryIn,  // Current carry flag.
	input  wire [4:0] opSel,    // Operation code.
	output reg  [7:0] aluRes,   // Result byte.
	output reg        aluNil,   // Result is zero.
	output reg        aluBorrow,// Borrow out of bit 7.
	output reg        aluHalf,  // Borrow out of bit 3.
	output reg        aluSkip,  // Skip condition.
	output reg        accWr,    // Result goes to accumulator.
	output reg        arithUpd, // Half carry and carry update.
	output reg        opValid   // Operation code is known.
);

	reg       subIn;
	reg [8:0] diff;
	reg [4:0] half;
	reg [7:0] andV;

	// Subtract path with borrow input, logic path and skip decision.
	always @* begin
		subIn = 1'b0;
		if (opSel == `IMA_OP_SBB)
			subIn = carryIn;
		if (opSel == `IMA_OP_GT)
			subIn = 1'b1;
		diff = {1'b0, accIn} - {1'b0, memIn} - {8'h00, subIn};
		half = {1'b0, accIn[3:0]} - {1'b0, memIn[3:0]} - {4'h0, subIn};
		andV = accIn & memIn;
		aluRes = diff[7:0];
		aluBorrow = diff[8];
		aluHalf = half[4];
		aluSkip = 1'b0;
		accWr = 1'b0;
		arithUpd = 1'b1;
		opValid = 1'b1;
		case (opSel)
			`IMA_OP_SUB, `IMA_OP_SBB: begin
				accWr = 1'b1;
			end
			`IMA_OP_SUBNB: begin
				accWr = 1'b1;
				aluSkip = ~diff[8];
			end
			`IMA_OP_AND: begin
				aluRes = andV;
				accWr = 1'b1;
				arithUpd = 1'b0;
			end
			`IMA_OP_OR: begin
				aluRes = accIn | memIn;
				accWr = 1'b1;
				arithUpd = 1'b0;
			end
			`IMA_OP_XOR: begin
				aluRes = accIn ^ memIn;
				accWr = 1'b1;
				arithUpd = 1'b0;
			end
			`IMA_OP_GT: aluSkip = ~diff[8];
			`IMA_OP_LT: aluSkip = diff[8];
			`IMA_OP_NE: aluSkip = |diff[7:0];
			`IMA_OP_EQ: aluSkip = ~|diff[7:0];
			`IMA_OP_ONTEST: begin
				aluRes = andV;
				aluSkip = |andV;
				arithUpd = 1'b0;
			end
			`IMA_OP_OFFTEST: begin
				aluRes = andV;
				aluSkip = ~|andV;
				arithUpd = 1'b0;
			end
			default: begin
				opValid = 1'b0;
				arithUpd = 1'b0;
			end
		endcase
		aluNil = ~|aluRes;
	end

endmodule // ima_alu

/* File: logic/ima_consts.vh */
// Constants of the indirect memory operand ALU block.
`ifndef IMA_CONSTS_VH
`define IMA_CONSTS_VH

// ----------------------------------------------------------------
// Instruction layout
// ----------------------------------------------------------------
`define IMA_OPC_FIRST   8'h70
`define IMA_OP_HI       7
`define IMA_OP_LO       3
`define IMA_PAIR_HI     2
`define IMA_PAIR_LO     0
`define IMA_EXEC_STATES 4'hB
`define IMA_INSN_BYTES  2

// ----------------------------------------------------------------
// Operation codes (upper five bits of the second byte)
// ----------------------------------------------------------------
`define IMA_OP_SUB      5'h1C
`define IMA_OP_SBB      5'h1E
`define IMA_OP_SUBNB    5'h16
`define IMA_OP_AND      5'h11
`define IMA_OP_OR       5'h13
`define IMA_OP_XOR      5'h12
`define IMA_OP_GT       5'h15
`define IMA_OP_LT       5'h17
`define IMA_OP_NE       5'h1D
`define IMA_OP_EQ       5'h1F
`define IMA_OP_ONTEST   5'h19
`define IMA_OP_OFFTEST  5'h1B

// ----------------------------------------------------------------
// Pair select codes
// ----------------------------------------------------------------
`define IMA_PS_ONE      3'h1
`define IMA_PS_TWO      3'h2
`define IMA_PS_THREE    3'h3
`define IMA_PS_TWO_INC  3'h4
`define IMA_PS_THR_INC  3'h5
`define IMA_PS_TWO_DEC  3'h6
`define IMA_PS_THR_DEC  3'h7

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define IMA_REG_INSN    8'h00
`define IMA_REG_ACC     8'h04
`define IMA_REG_FLAGS   8'h08
`define IMA_REG_PONE    8'h0C
`define IMA_REG_PTWO    8'h10
`define IMA_REG_PTHREE  8'h14
`define IMA_REG_STATUS  8'h18

// ----------------------------------------------------------------
// Flag and status bit positions, reset values
// ----------------------------------------------------------------
`define IMA_FL_NIL      0
`define IMA_FL_BYP      1
`define IMA_FL_HC       2
`define IMA_FL_CH1      3
`define IMA_FL_CH0      4
`define IMA_FL_CY       5
`define IMA_ST_BUSY     0
`define IMA_ST_SKIPPED  1
`define IMA_ST_ILLEGAL  2
`define IMA_RST_BYTE    8'h00
`define IMA_RST_PAIR    16'h0000
`define IMA_RST_FLAGS   6'h00

`endif

/* File: logic/ima_exec.v */
// Execution unit for memory operand subtract, logic, compare and test ops.
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "ima_consts.vh"

module ima_exec (
	input  wire        ref_clk,    // Processor clock.
	input  wire        sys_rst,    // Synchronous reset, active high.
	input  wire        psel,       // APB select.
	input  wire        penable,    // APB enable.
	input  wire        pwrite,     // APB write direction.
	input  wire [7:0]  paddr,      // APB byte address.
	input  wire [31:0] pwdata,     // APB write data.
	output wire [31:0] prdata,     // APB read data.
	output wire        pready,     // APB ready.
	output wire        pslverr,    // APB error.
	output wire [15:0] memAddr,    // Operand address.
	output wire        memRdEn,    // Operand read request.
	input  wire [7:0]  memRdData,  // Operand read data.
	input  wire        memAck      // Operand read accepted.
);

	// ----------------------------------------------------------------
	// State and registers
	// ----------------------------------------------------------------
	localparam ST_IDLE = 2'h0;
	localparam ST_READ = 2'h1;
	localparam ST_EXEC = 2'h2;

	reg [1:0]  state_q;
	reg [3:0]  cnt_q;
	reg [15:0] insn_q;
	reg [7:0]  acc_q;
	reg [5:0]  flags_q;
	reg [15:0] pOne_q;
	reg [15:0] pTwo_q;
	reg [15:0] pThree_q;
	reg [7:0]  memData_q;
	reg        skipped_q;
	reg        illegal_q;
	reg [31:0] prdata_q;
	reg        pready_q;
	reg        pslverr_q;
	reg [15:0] memAddr_q;
	reg        memRdEn_q;

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign memAddr = memAddr_q;
	assign memRdEn = memRdEn_q;

	// ----------------------------------------------------------------
	// Decode of the held instruction
	// ----------------------------------------------------------------
	wire [4:0] opSel = insn_q[`IMA_OP_HI:`IMA_OP_LO];
	wire [2:0] pairSel = insn_q[`IMA_PAIR_HI:`IMA_PAIR_LO];
	wire       busy = (state_q != ST_IDLE);

	wire [7:0] aluRes;
	wire       aluNil;
	wire       aluBorrow;
	wire       aluHalf;
	wire       aluSkip;
	wire       accWr;
	wire       arithUpd;
	wire       opValid;

	// Arithmetic on the captured operand byte.
	ima_alu uAlu (
		.accIn     (acc_q),
		.memIn     (memData_q),
		.carryIn   (flags_q[`IMA_FL_CY]),
		.opSel     (opSel),
		.aluRes    (aluRes),
		.aluNil    (aluNil),
		.aluBorrow (aluBorrow),
		.aluHalf   (aluHalf),
		.aluSkip   (aluSkip),
		.accWr     (accWr),
		.arithUpd  (arithUpd),
		.opValid   (opValid)
	);

	// ----------------------------------------------------------------
	// Decode of a newly written instruction word
	// ----------------------------------------------------------------
	wire [15:0] newInsn = pwdata[15:0];
	wire [4:0]  newOp = newInsn[`IMA_OP_HI:`IMA_OP_LO];
	wire [2:0]  newPair = newInsn[`IMA_PAIR_HI:`IMA_PAIR_LO];
	reg         newOpOk;

	// Known operation codes of this group.
	always @* begin
		case (newOp)
			`IMA_OP_SUB, `IMA_OP_SBB, `IMA_OP_SUBNB,
			`IMA_OP_AND, `IMA_OP_OR, `IMA_OP_XOR,
			`IMA_OP_GT, `IMA_OP_LT, `IMA_OP_NE, `IMA_OP_EQ,
			`IMA_OP_ONTEST, `IMA_OP_OFFTEST: newOpOk = 1'b1;
			default: newOpOk = 1'b0;
		endcase
	end

	// First byte, pair field and operation code must all be legal.
	wire newLegal = (newInsn[15:8] == `IMA_OPC_FIRST) &&
		(newPair != 3'h0) && newOpOk;

	reg [15:0] newAddr;

	// Operand address is the pair's current value.
	always @* begin
		case (newPair)
			`IMA_PS_ONE: newAddr = pOne_q;
			`IMA_PS_TWO, `IMA_PS_TWO_INC,
			`IMA_PS_TWO_DEC: newAddr = pTwo_q;
			`IMA_PS_THREE, `IMA_PS_THR_INC,
			`IMA_PS_THR_DEC: newAddr = pThree_q;
			default: newAddr = `IMA_RST_PAIR;
		endcase
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	wire apbAccess = psel & penable;
	wire apbDone = apbAccess & pready_q;
	wire mapped = (paddr == `IMA_REG_INSN) || (paddr == `IMA_REG_ACC) ||
		(paddr == `IMA_REG_FLAGS) || (paddr == `IMA_REG_PONE) ||
		(paddr == `IMA_REG_PTWO) || (paddr == `IMA_REG_PTHREE) ||
		(paddr == `IMA_REG_STATUS);
	wire blocked = pwrite & busy & (paddr != `IMA_REG_STATUS);
	wire bad = ~mapped | blocked;
	wire wrOk = apbDone & pwrite & ~pslverr_q;
	wire insnWr = wrOk & (paddr == `IMA_REG_INSN);
	wire skipNow = flags_q[`IMA_FL_BYP];
	wire start = insnWr & ~skipNow & newLegal;
	reg  [31:0] rdMux;

	// Read multiplexer; unused bits read as zero.
	always @* begin
		case (paddr)
			`IMA_REG_INSN:   rdMux = {16'h0000, insn_q};
			`IMA_REG_ACC:    rdMux = {24'h000000, acc_q};
			`IMA_REG_FLAGS:  rdMux = {26'h0000000, flags_q};
			`IMA_REG_PONE:   rdMux = {16'h0000, pOne_q};
			`IMA_REG_PTWO:   rdMux = {16'h0000, pTwo_q};
			`IMA_REG_PTHREE: rdMux = {16'h0000, pThree_q};
			`IMA_REG_STATUS: rdMux = {29'h00000000, illegal_q,
				skipped_q, busy};
			default:         rdMux = 32'h00000000;
		endcase
	end

	// Ready comes one cycle into the access phase, with data and error.
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= apbAccess & ~pready_q;
			if (apbAccess & ~pready_q) begin
				pslverr_q <= bad;
				prdata_q <= (pwrite | bad) ? 32'h00000000 : rdMux;
			end else begin
				pslverr_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Sequencer: read operand, hold to the state count, then commit
	// ----------------------------------------------------------------
	wire commit = (state_q == ST_EXEC) &&
		(cnt_q >= (`IMA_EXEC_STATES - 4'h1));

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
			cnt_q <= 4'h0;
			memRdEn_q <= 1'b0;
			memAddr_q <= `IMA_RST_PAIR;
			memData_q <= `IMA_RST_BYTE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					cnt_q <= 4'h0;
					if (start) begin
						state_q <= ST_READ;
						cnt_q <= 4'h1;
						memAddr_q <= newAddr;
						memRdEn_q <= 1'b1;
					end
				end
				ST_READ: begin
					if (cnt_q != 4'hF)
						cnt_q <= cnt_q + 4'h1;
					if (memAck) begin
						memData_q <= memRdData;
						memRdEn_q <= 1'b0;
						state_q <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					if (cnt_q != 4'hF)
						cnt_q <= cnt_q + 4'h1;
					if (commit)
						state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
					memRdEn_q <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Software write strobes
	// ----------------------------------------------------------------
	// Each strobe marks the edge where an error-free write completes.
	// Writes refused while busy never raise a strobe.
	wire accSwWr = wrOk & (paddr == `IMA_REG_ACC);
	wire flagsSwWr = wrOk & (paddr == `IMA_REG_FLAGS);
	wire pOneSwWr = wrOk & (paddr == `IMA_REG_PONE);
	wire pTwoSwWr = wrOk & (paddr == `IMA_REG_PTWO);
	wire pThreeSwWr = wrOk & (paddr == `IMA_REG_PTHREE);
	wire statusClr = wrOk & (paddr == `IMA_REG_STATUS);
	wire skipWr = insnWr & skipNow;
	wire illegalWr = insnWr & ~skipNow & ~newLegal;

	// ----------------------------------------------------------------
	// Architectural state: instruction, accumulator, flags, pairs
	// ----------------------------------------------------------------
	// Held instruction word; a skipped or illegal word stays readable.
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			insn_q <= 16'h0000;
		end else if (insnWr) begin
			insn_q <= newInsn;
		end
	end

	// Accumulator: only writing ops replace it at commit.
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			acc_q <= `IMA_RST_BYTE;
		end else if (commit) begin
			if (accWr & opValid)
				acc_q <= aluRes;
		end else if (accSwWr) begin
			// Software load, only possible while idle.
			acc_q <= pwdata[7:0];
		end
	end

	// Flags: outcome at commit; a discarded word uses up the bypass flag.
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			flags_q <= `IMA_RST_FLAGS;
		end else if (commit) begin
			flags_q[`IMA_FL_NIL] <= aluNil;
			flags_q[`IMA_FL_BYP] <= aluSkip;
			flags_q[`IMA_FL_CH1] <= 1'b0;
			flags_q[`IMA_FL_CH0] <= 1'b0;
			// Logic ops and tests keep both carries.
			if (arithUpd) begin
				flags_q[`IMA_FL_HC] <= aluHalf;
				flags_q[`IMA_FL_CY] <= aluBorrow;
			end
		end else if (flagsSwWr) begin
			flags_q <= pwdata[5:0];
		end else if (skipWr) begin
			flags_q[`IMA_FL_BYP] <= 1'b0;
		end
	end

	// Pairs: software writes, or one step after the operand access.
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			pOne_q <= `IMA_RST_PAIR;
			pTwo_q <= `IMA_RST_PAIR;
			pThree_q <= `IMA_RST_PAIR;
		end else if (commit) begin
			// Post-step of the pair that addressed the operand.
			case (pairSel)
				`IMA_PS_TWO_INC: pTwo_q <= pTwo_q + 16'h0001;
				`IMA_PS_THR_INC: pThree_q <= pThree_q + 16'h0001;
				`IMA_PS_TWO_DEC: pTwo_q <= pTwo_q - 16'h0001;
				`IMA_PS_THR_DEC: pThree_q <= pThree_q - 16'h0001;
				default: pOne_q <= pOne_q;
			endcase
		end else begin
			// Software loads; one address means one pair at a time.
			if (pOneSwWr)
				pOne_q <= pwdata[15:0];
			if (pTwoSwWr)
				pTwo_q <= pwdata[15:0];
			if (pThreeSwWr)
				pThree_q <= pwdata[15:0];
		end
	end

	// Sticky status: an event wins over a clear in the same cycle, so
	// software never loses a skip or an illegal word it has not seen.
	// A status clear may land while busy, so it has its own process.
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			skipped_q <= 1'b0;
			illegal_q <= 1'b0;
		end else begin
			if (skipWr)
				skipped_q <= 1'b1;
			else if (statusClr & pwdata[`IMA_ST_SKIPPED])
				skipped_q <= 1'b0;
			if (illegalWr)
				illegal_q <= 1'b1;
			else if (statusClr & pwdata[`IMA_ST_ILLEGAL])
				illegal_q <= 1'b0;
		end
	end

endmodule // ima_exec

/* File: testbench/ima_exec_props.sv */
// Checker of the operand fetch handshake of the execution unit.
`timescale 1ns/1ps
`include "ima_consts.vh"

module ima_exec_props (
	input wire        ref_clk,  // Processor clock.
	input wire        sys_rst,  // Synchronous reset.
	input wire        psel,     // APB select.
	input wire        penable,  // APB enable.
	input wire        pwrite,   // APB direction.
	input wire [7:0]  paddr,    // APB address.
	input wire [31:0] pwdata,   // APB write data.
	input wire        pready,   // APB ready.
	input wire        pslverr,  // APB error.
	input wire [15:0] memAddr,  // Operand address.
	input wire        memRdEn,  // Operand request.
	input wire        memAck    // Operand accept.
);
	// ------------------------------------------------------------
	// Helper logic
	// ------------------------------------------------------------
	// Completed writes and the instruction fields they carry.
	wire        apbWr  = psel && penable && pready && pwrite;
	wire        insnWr = apbWr && paddr == `IMA_REG_INSN;
	wire [7:0]  insnHi = pwdata[15:8];
	wire [2:0]  insnPs = pwdata[2:0];
	reg  [15:0] pOneQ;
	// Tracks the first pair, which no mode ever steps.
	always @(posedge ref_clk) begin
		if (sys_rst)
			pOneQ <= 16'h0000;
		else if (apbWr && !pslverr && paddr == `IMA_REG_PONE)
			pOneQ <= pwdata[15:0];
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence s_wait; memRdEn && !memAck; endsequence
	sequence s_start; $rose(memRdEn); endsequence
	property p_hold; s_wait |=> memRdEn && $stable(memAddr); endproperty
	property p_drop; memRdEn && memAck |=> !memRdEn; endproperty
	property p_cause; s_start |-> $past(insnWr); endproperty
	property p_word;
		s_start |-> $past(insnHi) == `IMA_OPC_FIRST && $past(insnPs) != 3'h0;
	endproperty
	property p_badHi;
		insnWr && !memRdEn && insnHi != `IMA_OPC_FIRST |=> !memRdEn;
	endproperty
	property p_badPs; insnWr && !memRdEn && insnPs == 3'h0 |=> !memRdEn;
	endproperty
	property p_space; s_start |=> (!$rose(memRdEn)) [*8]; endproperty
	property p_pair;
		s_start and ($past(insnPs) == `IMA_PS_ONE) |-> memAddr == pOneQ;
	endproperty
	a_hold: assert property (p_hold)
		else $error("operand request changed before accept");
	a_drop: assert property (p_drop)
		else $error("operand request kept after accept");
	a_cause: assert property (p_cause)
		else $error("operand read without instruction write");
	a_word: assert property (p_word)
		else $error("operand read for a foreign word");
	a_badHi: assert property (p_badHi)
		else $error("wrong first byte started a read");
	a_badPs: assert property (p_badPs)
		else $error("pair code zero started a read");
	a_space: assert property (p_space)
		else $error("reads closer than one instruction");
	a_pair: assert property (p_pair)
		else $error("first pair mode used a wrong address");
endmodule // ima_exec_props

/* File: testbench/ima_mem_model.sv */
// Behavioural data memory answering operand read requests.
`timescale 1ns/1ps

module ima_mem_model (
	input  wire        ref_clk,   // Processor clock.
	input  wire        sys_rst,   // Synchronous reset.
	input  wire [3:0]  slowCyc,   // Wait cycles before accept.
	input  wire [15:0] memAddr,   // Operand address.
	input  wire        memRdEn,   // Read request.
	output reg         memAck,    // Accept, one cycle.
	output wire [7:0]  memRdData  // Operand byte.
);
	reg [7:0] mem [0:255];
	reg [7:0] lastQ = 8'h00;
	reg [3:0] waitQ;
	integer   k;
	// Each byte holds its own address, so a wrong pair shows up.
	initial for (k = 0; k < 256; k = k + 1) mem[k] = k[7:0];
	// Off the accept cycle the line shows the inverse of its last value.
	assign memRdData = memAck ? mem[memAddr[7:0]] : ~lastQ;
	// Waits, accepts once, then idles until the next request.
	always @(posedge ref_clk) begin
		if (sys_rst || !memRdEn || memAck) begin
			waitQ <= 4'h0;
			memAck <= 1'b0;
		end else if (waitQ >= slowCyc)
			memAck <= 1'b1;
		else
			waitQ <= waitQ + 4'h1;
		if (memAck)
			lastQ <= memRdData;
	end
endmodule // ima_mem_model

/* File: testbench/test_ima_exec.sv */
// Self-checking bench of the memory operand execution unit.
`timescale 1ns/1ps
`include "ima_consts.vh"

module test_ima_exec;
	localparam [59:0] OPS = {`IMA_OP_SUB, `IMA_OP_SBB, `IMA_OP_SUBNB,
		`IMA_OP_AND, `IMA_OP_OR, `IMA_OP_XOR, `IMA_OP_GT, `IMA_OP_LT,
		`IMA_OP_NE, `IMA_OP_EQ, `IMA_OP_ONTEST, `IMA_OP_OFFTEST};
	reg         ref_clk = 1'b0, sys_rst = 1'b1;
	reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	reg  [7:0]  paddr = 8'h00, a, m, pr;
	reg  [31:0] pwdata = 32'h00000000, rdat;
	reg  [3:0]  slowCyc = 4'h0;
	reg         rerr = 1'b0;
	reg  [4:0]  op;
	reg  [2:0]  ps;
	reg  [15:0] pv;
	reg  [13:0] e;
	wire [31:0] prdata;
	wire [15:0] memAddr;
	wire [7:0]  memRdData;
	wire        pready, pslverr, memRdEn, memAck;
	integer     i, failCount = 0, cmpCount = 0;

	// ------------------------------------------------------------
	// Design, memory and clock
	// ------------------------------------------------------------
	ima_exec u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .memAddr(memAddr), .memRdEn(memRdEn),
		.memRdData(memRdData), .memAck(memAck));
	ima_mem_model u_mem (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.slowCyc(slowCyc), .memAddr(memAddr), .memRdEn(memRdEn),
		.memAck(memAck), .memRdData(memRdData));
	// Clock of 25 ns.
	always #12.5 ref_clk = ~ref_clk;

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	// Counts a comparison and reports a mismatch.
	task check(input [31:0] seen, input [31:0] exp);
		begin
			cmpCount = cmpCount + 1;
			if (seen !== exp) begin
				failCount = failCount + 1;
				$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	// One APB transfer; read data is taken at the ready edge.
	task apb(input [7:0] ad, input w, input [31:0] d);
		begin
			@(posedge ref_clk);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= ad;
			pwdata <= d;
			@(posedge ref_clk);
			penable <= 1'b1;
			// Only the watchdog ends a wait that never sees ready.
			do @(posedge ref_clk);
			while (pready !== 1'b1);
			rdat = prdata;
			rerr = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	// Starts an instruction and polls until the unit is idle.
	task execOp(input [4:0] o, input [2:0] s);
		begin
			apb(`IMA_REG_INSN, 1'b1, {16'h0000, `IMA_OPC_FIRST, o, s});
			do apb(`IMA_REG_STATUS, 1'b0, 32'h00000000);
			while (rdat[0] !== 1'b0);
		end
	endtask
	// Expected accumulator and flags of one operation.
	function [13:0] expOf(input [4:0] o, input [7:0] x, input [7:0] y,
		input [5:0] f);
		reg [8:0] d;
		reg [4:0] h;
		reg [7:0] r;
		reg       bi, lg, kp, sk;
		begin
			bi = (o == `IMA_OP_SBB) ? f[5] : (o == `IMA_OP_GT);
			d = {1'b0, x} - {1'b0, y} - {8'h00, bi};
			h = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, bi};
			lg = o == `IMA_OP_AND || o == `IMA_OP_OR || o == `IMA_OP_XOR
				|| o == `IMA_OP_ONTEST || o == `IMA_OP_OFFTEST;
			kp = o == `IMA_OP_GT || o == `IMA_OP_LT || o == `IMA_OP_NE
				|| o == `IMA_OP_EQ || o == `IMA_OP_ONTEST
				|| o == `IMA_OP_OFFTEST;
			case (o)
				`IMA_OP_AND, `IMA_OP_ONTEST, `IMA_OP_OFFTEST: r = x & y;
				`IMA_OP_OR: r = x | y;
				`IMA_OP_XOR: r = x ^ y;
				default: r = d[7:0];
			endcase
			case (o)
				`IMA_OP_SUBNB, `IMA_OP_GT: sk = !d[8];
				`IMA_OP_LT: sk = d[8];
				`IMA_OP_NE, `IMA_OP_ONTEST: sk = r != 8'h00;
				`IMA_OP_EQ, `IMA_OP_OFFTEST: sk = r == 8'h00;
				default: sk = 1'b0;
			endcase
			expOf = {kp ? x : r, lg ? f[5] : d[8], 2'b00,
				lg ? f[2] : h[4], sk, r == 8'h00};
		end
	endfunction
	// Prints the counts and the verdict, then stops.
	task conclude;
		begin
			$display("compares %0d mismatches %0d", cmpCount, failCount);
			if (failCount == 0 && cmpCount > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	// Illegal words, then each operation three times with rotating pair modes, below, equal and disjoint, then a skip.
	initial begin
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		apb(8'h1C, 1'b0, 32'h00000000);
		check(rerr, 32'h00000001);
		check(rdat, 32'h00000000);
		apb(`IMA_REG_INSN, 1'b1, {16'h0000, 8'h71, `IMA_OP_SUB, 3'h1});
		apb(`IMA_REG_STATUS, 1'b0, 32'h00000000);
		check(rdat & 32'h00000004, 32'h00000004);
		apb(`IMA_REG_STATUS, 1'b1, 32'h00000006);
		execOp(`IMA_OP_SUB, 3'h0);
		check(rdat & 32'h00000004, 32'h00000004);
		apb(`IMA_REG_STATUS, 1'b1, 32'h00000006);
		$display("test illegal done");
		for (i = 0; i < 36; i = i + 1) begin
			op = OPS[59 - 5 * (i % 12) -: 5];
			ps = i % 7 + 1;
			m = 8'h40 + i;
			a = (i < 12) ? m - 8'h01 : (i < 24) ? m : ~m;
			pv = {8'h12, m};
			pr = (ps == 3'h1) ? `IMA_REG_PONE
				: ps[0] ? `IMA_REG_PTHREE : `IMA_REG_PTWO;
			apb(`IMA_REG_ACC, 1'b1, {24'h000000, a});
			apb(`IMA_REG_FLAGS, 1'b1, 32'h0000003C);
			apb(pr, 1'b1, {16'h0000, pv});
			execOp(op, ps);
			e = expOf(op, a, m, 6'h3C);
			apb(`IMA_REG_ACC, 1'b0, 32'h00000000);
			check(rdat, {24'h000000, e[13:6]});
			apb(`IMA_REG_FLAGS, 1'b0, 32'h00000000);
			check(rdat, {26'h0, e[5:0]});
			check(rdat[1], e[1]);
			apb(pr, 1'b0, 32'h00000000);
			check(rdat, {16'h0000, ps < 4 ? pv : ps < 6 ? pv + 16'h0001
				: pv - 16'h0001});
		end
		$display("test operations done");
		slowCyc <= 4'h5;
		apb(`IMA_REG_PONE, 1'b1, 32'h00001240);
		apb(`IMA_REG_FLAGS, 1'b1, 32'h00000000);
		execOp(`IMA_OP_NE, `IMA_PS_ONE);
		execOp(`IMA_OP_SUB, `IMA_PS_ONE);
		apb(`IMA_REG_STATUS, 1'b0, 32'h00000000);
		check(rdat, 32'h00000002);
		apb(`IMA_REG_ACC, 1'b0, 32'h00000000);
		check(rdat, {24'h000000, a});
		execOp(`IMA_OP_SUB, `IMA_PS_ONE);
		apb(`IMA_REG_ACC, 1'b0, 32'h00000000);
		check(rdat, {24'h000000, a - 8'h40});
		$display("test skip done");
		conclude;
	end
	// Cuts a hang short after far more cycles than the tests need.
	initial begin
		#(25 * 20000);
		failCount = failCount + 1;
		conclude;
	end
endmodule // test_ima_exec

bind ima_exec ima_exec_props u_props (.ref_clk(ref_clk),
	.sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.memAddr(memAddr), .memRdEn(memRdEn), .memAck(memAck));
